/* rtl/emm_defs.svh */
// Constants of the metrology engine: rates, frame limits, fixed points.
// Assumes inclusion by bare name from every file that needs them.
`ifndef EMM_DEFS_SVH
`define EMM_DEFS_SVH
`define EMM_FS        32'd8000     // Nominal sample rate, Hz
`define EMM_FRAME_MIN 16'd7900     // Frame closes at first crossing past it
`define EMM_FRAME_MAX 16'd8400     // Forced close without crossings
`define EMM_SPC_RST   32'h0000a000 // 160.0 samples per cycle, q8
`define EMM_DLY_RST   32'h00002800 // 40.0 samples quarter cycle, q8
`define EMM_FRQ_NUM   (64'(`EMM_FS) * 64'd25600) // Fs * 100 * 256
`define EMM_PF_FRAC   14           // Power factor fraction bits
`define EMM_K_FRAC    16           // Scaling factor fraction bits
`define EMM_SQRT_STEPS 7'd32
`define EMM_DIV_STEPS  7'd64
`endif

/* rtl/emm_pkg.sv */
// Types shared by the metrology engine and its arithmetic unit.
// Assumes nothing of its surroundings.
package emm_pkg;
  typedef struct packed {
    logic signed [23:0] v;
    logic signed [23:0] i;
  } emm_smp_t;
  typedef struct packed {
    logic signed [31:0] kv, ki, kp, kq, ov, oi, op, oq;
  } emm_cal_t;
  typedef struct packed {
    logic [31:0]        vrms, irms;
    logic signed [31:0] p, q;
    logic [31:0]        s;
    logic signed [15:0] pf;
  } emm_res_t;
  typedef struct packed {
    logic [63:0] act_imp, act_exp, rq1, rq2, rq3, rq4, app_imp, app_exp;
  } emm_nrg_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_SPC = 4'h1, S_FRQ = 4'h2, S_DV  = 4'h3,
    S_SQV  = 4'h4, S_DI  = 4'h5, S_SQI = 4'h6, S_DP  = 4'h7,
    S_DQ   = 4'h8, S_SQS = 4'h9, S_PF  = 4'ha, S_ACC = 4'hb
  } emm_st_t;
endpackage

/* rtl/emm_math.sv */
// Serial unsigned divider (64/32) and square root (64 -> 32).
// Assumes start is only raised while idle; one result per request.
`include "emm_defs.svh"
module emm_math import emm_pkg::*; (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Request
  input  wire logic        start,
  input  wire logic        op_sqrt,
  input  wire logic [63:0] a,
  input  wire logic [31:0] b,
  // Answer
  output logic             done,
  output logic [63:0]      res
);
  logic        busy_r, sq_r, done_r;
  logic [6:0]  cnt_r;
  logic [63:0] a_r, q_r, res_r;
  logic [35:0] rem_r;
  logic [31:0] b_r;
  wire  [35:0] sq_rem = {rem_r[33:0], a_r[63:62]};
  wire  [35:0] trial  = {2'b00, q_r[31:0], 2'b01};
  wire  [35:0] dv_rem = {rem_r[34:0], a_r[63]};
  wire         sq_ok  = sq_rem >= trial;
  wire         dv_ok  = dv_rem >= {4'h0, b_r};
  wire         bit_ok = sq_r ? sq_ok : dv_ok;
  wire  [35:0] rem_nxt = sq_r ? (sq_ok ? sq_rem - trial : sq_rem)
                              : (dv_ok ? dv_rem - {4'h0, b_r} : dv_rem);
  wire  [63:0] q_nxt  = {q_r[62:0], bit_ok};
  wire  [63:0] a_nxt  = sq_r ? {a_r[61:0], 2'b00} : {a_r[62:0], 1'b0};

  assign done = done_r;
  assign res  = res_r;

  // One restoring step per clock
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      sq_r   <= 1'b0;
      done_r <= 1'b0;
      cnt_r  <= 7'h00;
      a_r    <= 64'h0;
      q_r    <= 64'h0;
      rem_r  <= 36'h0;
      b_r    <= 32'h0;
      res_r  <= 64'h0;
    end else begin
      done_r <= 1'b0;
      if (start && !busy_r) begin
        busy_r <= 1'b1;
        sq_r   <= op_sqrt;
        a_r    <= a;
        b_r    <= b;
        q_r    <= 64'h0;
        rem_r  <= 36'h0;
        cnt_r  <= op_sqrt ? `EMM_SQRT_STEPS : `EMM_DIV_STEPS;
      end else if (busy_r) begin
        a_r   <= a_nxt;
        q_r   <= q_nxt;
        rem_r <= rem_nxt;
        cnt_r <= cnt_r - 7'h01;
        if (cnt_r == 7'h01) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
          res_r  <= q_nxt;
        end
      end
    end
  end

  sqrt_lat_a: assert property (@(posedge clk) disable iff (!rst_n)
    start && !busy_r && op_sqrt |-> ##33 done)
    else $error("square root answer late or early");
  div_lat_a: assert property (@(posedge clk) disable iff (!rst_n)
    start && !busy_r && !op_sqrt |-> ##65 done)
    else $error("division answer late or early");
endmodule

/* rtl/emm_engine.sv */
// Metrology engine: frame sums, RMS, powers, frequency, energy totals.
// Assumes one simultaneous v/i sample set per smp_vld, in the clk domain.
`include "emm_defs.svh"
// Overview of operation
// - Frames of about one second use every sample and keep their count.
// - RMS is scale times root of mean square, minus noise offset.
// - Active power is scale times mean of v*i, minus crosstalk offset.
// - Reactive power is scale times mean of shifted v times i, minus offset.
// - Quarter-cycle delay follows the measured mains frequency.
// - Delay is whole samples plus table-driven one-tap interpolation.
// - Frame energies are frame powers times frame sample count.
// - Energy totals run from reset.
// - NPH+1 total sets: one per phase plus the phase sum.
// - Non-negative active energy goes to import, negative to export.
// - Reactive energy goes to quadrant chosen by reactive and active signs.
// - Apparent energy goes to import if active non-negative, else export.
// - Frequency is sample rate divided by measured samples per cycle.
// - Power factor magnitude is active over apparent, positive capacitive.
// - Power factor sign follows current leading or lagging voltage.
// - Each per-sample sum sits in its own 64-bit accumulator.
// - Apparent power comes from the frame's active and reactive power.
module emm_engine import emm_pkg::*; #(
  parameter int NPH   = 3,
  parameter int DEPTH = 64
) (
  // Clock and reset
  input  wire logic     clk,
  input  wire logic     rst_n,
  // Sample stream
  input  wire logic     smp_vld,
  input  wire emm_smp_t smp [NPH],
  // Calibration per phase
  input  wire emm_cal_t cal [NPH],
  // Frame results
  output logic          frame_done,
  output emm_res_t      res [NPH],
  output logic [31:0]   freq_chz,
  output logic [31:0]   spc_q8,
  // Energy totals, last entry is the phase sum
  output emm_nrg_t      nrg [NPH+1]
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [8:0] FIR_LUT [16] = '{
    9'h008, 9'h018, 9'h028, 9'h038, 9'h048, 9'h058, 9'h068, 9'h078,
    9'h088, 9'h098, 9'h0a8, 9'h0b8, 9'h0c8, 9'h0d8, 9'h0e8, 9'h0f8};

  if (NPH < 1 || NPH > 3 || DEPTH < 64 || DEPTH != 2 ** AW) begin : g_chk
    $error("NPH must be 1..3 and DEPTH a power of two of at least 64");
  end

  emm_st_t            st_r;
  logic [1:0]         ph_r;
  logic               pend_r, fdone_r, vneg_r;
  logic [15:0]        cnt_r, cnt_s_r, cyc_r, cyc_s_r;
  logic [AW-1:0]      wp_r;
  logic [31:0]        dly_r, spc_r, freq_r, s_r;
  logic signed [31:0] p_r, q_r;
  logic [63:0]        t_r, fs_r, m_a, m_res, e_s;
  logic signed [63:0] fa_r, fq_r, e_a, e_q;
  logic signed [63:0] sv_r [NPH], si_r [NPH], sp_r [NPH], sq_r [NPH];
  logic signed [63:0] sv_s [NPH], si_s [NPH], sp_s [NPH], sq_s [NPH];
  logic signed [23:0] dly_mem [NPH][DEPTH];
  logic [31:0]        m_b;
  logic               m_sq, m_done;
  emm_res_t           res_r [NPH];
  emm_nrg_t           nrg_r [NPH+1];
  emm_nrg_t           nrg_nxt;

  function automatic logic [63:0] mag(input logic signed [63:0] x);
    return x[63] ? 64'(-x) : 64'(x);
  endfunction

  // Mean to real units: k * m >> frac, minus offset
  function automatic logic signed [31:0] scale(input logic [63:0] m,
      input logic neg, input logic signed [31:0] k, off);
    logic signed [48:0] sm;
    logic signed [81:0] pr;
    sm = neg ? -$signed({1'b0, m[47:0]}) : $signed({1'b0, m[47:0]});
    pr = sm * k;
    return pr[`EMM_K_FRAC+31:`EMM_K_FRAC] - off;
  endfunction

  // Frame boundary on rising crossing of phase 0 voltage
  wire        zc      = smp_vld && vneg_r && !smp[0].v[23];
  wire        fe      = smp_vld && ((zc && cnt_r >= `EMM_FRAME_MIN) ||
                                    cnt_r >= `EMM_FRAME_MAX);
  wire [15:0] cyc_end = cyc_r + 16'(zc);
  wire        m_go    = st_r != S_IDLE && st_r != S_ACC && !pend_r;
  wire        last_ph = ph_r == 2'(NPH);

  assign frame_done = fdone_r;
  assign res        = res_r;
  assign nrg        = nrg_r;
  assign freq_chz   = freq_r;
  assign spc_q8     = spc_r;

  // Sample counter, cycle counter, delay write pointer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r   <= 16'h0000;
      cyc_r   <= 16'h0000;
      cnt_s_r <= 16'h0000;
      cyc_s_r <= 16'h0000;
      wp_r    <= '0;
      vneg_r  <= 1'b0;
    end else if (smp_vld) begin
      wp_r   <= wp_r + 1'b1;
      vneg_r <= smp[0].v[23];
      cnt_r  <= fe ? 16'h0001 : cnt_r + 16'h0001;
      cyc_r  <= fe ? 16'h0000 : cyc_end;
      if (fe) begin
        cnt_s_r <= cnt_r;
        cyc_s_r <= cyc_end;
      end
    end
  end

  for (genvar g = 0; g < NPH; g++) begin : g_ph
    logic [AW-1:0]      a0, a1;
    logic [8:0]         c1;
    logic signed [23:0] o0, o1, v90;
    logic signed [34:0] mix;
    logic signed [47:0] vv, ii, vi, qi;
    // whole part from delay line, fraction by one tap
    assign a0  = wp_r - dly_r[AW+7:8];
    assign a1  = a0 - 1'b1;
    assign o0  = dly_mem[g][a0];
    assign o1  = dly_mem[g][a1];
    assign c1  = FIR_LUT[dly_r[7:4]];
    assign mix = $signed({1'b0, 9'h100 - c1}) * o0 + $signed({1'b0, c1}) * o1;
    assign v90 = mix[31:8];
    assign vv  = smp[g].v * smp[g].v;
    assign ii  = smp[g].i * smp[g].i;
    assign vi  = smp[g].v * smp[g].i;
    assign qi  = v90 * smp[g].i;
    // Voltage history for the quarter-cycle shift
    always_ff @(posedge clk) begin
      if (smp_vld) dly_mem[g][wp_r] <= smp[g].v;
    end
    // separate 64-bit sums, snapshot at frame close
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        {sv_r[g], si_r[g], sp_r[g], sq_r[g]} <= '0;
        {sv_s[g], si_s[g], sp_s[g], sq_s[g]} <= '0;
      end else if (smp_vld) begin
        sv_r[g] <= fe ? 64'(vv) : sv_r[g] + 64'(vv);
        si_r[g] <= fe ? 64'(ii) : si_r[g] + 64'(ii);
        sp_r[g] <= fe ? 64'(vi) : sp_r[g] + 64'(vi);
        sq_r[g] <= fe ? 64'(qi) : sq_r[g] + 64'(qi);
        if (fe) begin
          {sv_s[g], si_s[g], sp_s[g], sq_s[g]} <=
            {sv_r[g], si_r[g], sp_r[g], sq_r[g]};
        end
      end
    end
  end

  // Operand selection for the arithmetic unit
  always_comb begin
    m_sq = 1'b0;
    m_a  = t_r;
    m_b  = {16'h0000, cnt_s_r};
    unique case (st_r)
      S_SPC: begin
        m_a = {40'h0, cnt_s_r, 8'h00};
        m_b = {16'h0000, cyc_s_r};
      end
      S_FRQ: begin
        m_a = `EMM_FRQ_NUM;
        m_b = spc_r;
      end
      S_DV: m_a = sv_s[ph_r];
      S_DI: m_a = si_s[ph_r];
      S_DP: m_a = mag(sp_s[ph_r]);
      S_DQ: m_a = mag(sq_s[ph_r]);
      S_SQV, S_SQI: m_sq = 1'b1;
      S_SQS: begin
        // root of p squared plus q squared
        m_sq = 1'b1;
        m_a  = 64'(p_r) * 64'(p_r) + 64'(q_r) * 64'(q_r);
      end
      S_PF: begin
        m_a = mag(64'(p_r)) << `EMM_PF_FRAC;
        m_b = s_r;
      end
      default: ;
    endcase
  end

  emm_math u_math (
    .clk     (clk),
    .rst_n   (rst_n),
    .start   (m_go),
    .op_sqrt (m_sq),
    .a       (m_a),
    .b       (m_b),
    .done    (m_done),
    .res     (m_res)
  );

  // frame energies; last pass uses the phase sum
  // Widen before multiplying so the product keeps all 64 bits
  assign e_a = last_ph ? fa_r : 64'(p_r) * $signed({48'h0, cnt_s_r});
  assign e_q = last_ph ? fq_r : 64'(q_r) * $signed({48'h0, cnt_s_r});
  assign e_s = last_ph ? fs_r : 64'(s_r) * 64'(cnt_s_r);

  // Energy steering into the selected total set
  always_comb begin
    nrg_nxt = nrg_r[ph_r];
    if (e_a[63]) nrg_nxt.act_exp = nrg_nxt.act_exp + mag(e_a);
    else         nrg_nxt.act_imp = nrg_nxt.act_imp + 64'(e_a);
    // quadrant by reactive and active signs
    unique case ({e_q[63], e_a[63]})
      2'b00: nrg_nxt.rq1 = nrg_nxt.rq1 + mag(e_q);
      2'b01: nrg_nxt.rq2 = nrg_nxt.rq2 + mag(e_q);
      2'b11: nrg_nxt.rq3 = nrg_nxt.rq3 + mag(e_q);
      2'b10: nrg_nxt.rq4 = nrg_nxt.rq4 + mag(e_q);
    endcase
    if (e_a[63]) nrg_nxt.app_exp = nrg_nxt.app_exp + e_s;
    else         nrg_nxt.app_imp = nrg_nxt.app_imp + e_s;
  end

  // totals from reset, one set per phase plus sum
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int k = 0; k <= NPH; k++) nrg_r[k] <= '0;
    end else if (st_r == S_ACC) begin
      nrg_r[ph_r] <= nrg_nxt;
    end
  end

  // Frame computation sequence
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r    <= S_IDLE;
      ph_r    <= 2'h0;
      pend_r  <= 1'b0;
      fdone_r <= 1'b0;
      {t_r, p_r, q_r, s_r, freq_r} <= '0;
      {fa_r, fq_r, fs_r} <= '0;
      spc_r   <= `EMM_SPC_RST;
      dly_r   <= `EMM_DLY_RST;
      for (int k = 0; k < NPH; k++) res_r[k] <= '0;
    end else begin
      fdone_r <= 1'b0;
      pend_r  <= (pend_r | m_go) & ~m_done;
      if (st_r == S_IDLE) begin
        if (fe) begin
          ph_r <= 2'h0;
          {fa_r, fq_r, fs_r} <= '0;
          st_r <= (cyc_end != 16'h0000) ? S_SPC : S_DV;
        end
      end else if (st_r == S_ACC) begin
        if (!last_ph) begin
          fa_r <= fa_r + e_a;
          fq_r <= fq_r + e_q;
          fs_r <= fs_r + e_s;
        end
        ph_r    <= ph_r + 2'h1;
        st_r    <= last_ph ? S_IDLE : (ph_r == 2'(NPH - 1)) ? S_ACC : S_DV;
        fdone_r <= last_ph;
        if (last_ph) ph_r <= 2'h0;
      end else if (m_done) begin
        unique case (st_r)
          S_SPC: begin
            // quarter of samples per cycle sets the delay
            spc_r <= m_res[31:0];
            dly_r <= {2'b00, m_res[31:2]};
            st_r  <= S_FRQ;
          end
          S_FRQ: begin freq_r <= m_res[31:0]; st_r <= S_DV; end
          S_DV:  begin t_r <= m_res; st_r <= S_SQV; end
          S_SQV: begin
            res_r[ph_r].vrms <= scale(m_res, 1'b0, cal[ph_r].kv, cal[ph_r].ov);
            st_r <= S_DI;
          end
          S_DI:  begin t_r <= m_res; st_r <= S_SQI; end
          S_SQI: begin
            res_r[ph_r].irms <= scale(m_res, 1'b0, cal[ph_r].ki, cal[ph_r].oi);
            st_r <= S_DP;
          end
          S_DP: begin
            p_r <= scale(m_res, sp_s[ph_r][63], cal[ph_r].kp, cal[ph_r].op);
            res_r[ph_r].p <= scale(m_res, sp_s[ph_r][63], cal[ph_r].kp,
                                   cal[ph_r].op);
            st_r <= S_DQ;
          end
          S_DQ: begin
            q_r <= scale(m_res, sq_s[ph_r][63], cal[ph_r].kq, cal[ph_r].oq);
            res_r[ph_r].q <= scale(m_res, sq_s[ph_r][63], cal[ph_r].kq,
                                   cal[ph_r].oq);
            st_r <= S_SQS;
          end
          S_SQS: begin
            s_r <= m_res[31:0];
            res_r[ph_r].s <= m_res[31:0];
            st_r <= S_PF;
          end
          S_PF: begin
            // magnitude, sign negative when current lags
            res_r[ph_r].pf <= (s_r == 32'h0) ? 16'h0000 :
                              q_r[31] ? m_res[15:0] : 16'(-m_res[15:0]);
            st_r <= S_ACC;
          end
          default: st_r <= S_IDLE;
        endcase
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire [63:0] cur_imp = nrg_r[ph_r].act_imp;
  wire [63:0] cur_q4  = nrg_r[ph_r].rq4;
  wire [63:0] cur_ax  = nrg_r[ph_r].app_exp;
  wire [63:0] eq_mag  = mag(e_q);
  wire        q_neg   = q_r[31];
  wire [63:0] vv0     = 64'(g_ph[0].vv);

  frame_cnt_a: assert property (smp_vld && !fe |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("sample count did not advance");
  frame_snap_a: assert property (fe |=> cnt_s_r == $past(cnt_r) && cnt_r == 16'h0001)
    else $error("frame count not captured");
  acc_add_a: assert property (smp_vld && !fe |=> sv_r[0] == $past(sv_r[0]) + $past(vv0))
    else $error("square sum not accumulated");
  delay_track_a: assert property (st_r == S_SPC && m_done |=> dly_r == 32'($past(m_res) >> 2))
    else $error("delay does not follow frequency");
  freq_div_a: assert property (st_r == S_FRQ && m_done && spc_r != 0 |=> 64'(freq_r) * 64'(spc_r) <= `EMM_FRQ_NUM)
    else $error("frequency exceeds rate over period");
  act_imp_a: assert property (st_r == S_ACC && !e_a[63] |=> nrg_r[$past(ph_r)].act_imp == $past(cur_imp) + $past(e_a))
    else $error("active import not added");
  quad_four_a: assert property (st_r == S_ACC && e_q[63] && !e_a[63] |=> nrg_r[$past(ph_r)].rq4 == $past(cur_q4) + $past(eq_mag))
    else $error("fourth quadrant not added");
  app_exp_a: assert property (st_r == S_ACC && e_a[63] |=> nrg_r[$past(ph_r)].app_exp == $past(cur_ax) + $past(e_s))
    else $error("apparent export not added");
  pf_sign_a: assert property (st_r == S_PF && m_done && s_r != 0 && m_res[15:0] != 0 |=> res_r[$past(ph_r)].pf[15] == !$past(q_neg))
    else $error("power factor sign wrong");
  seq_start_a: assert property (st_r == S_IDLE && fe |=> st_r inside {S_SPC, S_DV})
    else $error("frame close did not start computing");

  frame_c: cover property (fe ##1 st_r == S_SPC);
  quad_two_c: cover property (st_r == S_ACC && !e_q[63] && e_a[63]);
  sum_set_c: cover property (st_r == S_ACC && last_ph);
  pf_ind_c: cover property (fdone_r && res_r[0].pf[15]);
endmodule

/* verif/emm_src_model.sv */
// Sample source model: square-wave voltage and current pairs per phase.
// Assumes a single clock; restarts its waveform at every reset.
module emm_src_model import emm_pkg::*; #(
  parameter int             NPH   = 3,
  parameter int             GAP   = 1,
  parameter int             HALF  = 64,
  parameter int             AMP_V = 1000,
  parameter int             AMP_I = 2000,
  parameter logic [NPH-1:0] INV   = '0
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Sample stream
  output emm_smp_t  smp [NPH],
  output logic      smp_vld
);
  int unsigned idx_r;
  int unsigned gap_r;
  logic        pos;

  // Positive half of the current period
  assign pos = (idx_r % (2 * HALF)) < HALF;

  // Defined levels before the first edge
  initial begin
    smp_vld = 1'b0;
    idx_r   = 0;
    gap_r   = 0;
    for (int k = 0; k < NPH; k++)
      smp[k] = '0;
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      idx_r   <= 0;
      gap_r   <= 0;
      smp_vld <= 1'b0;
    end else begin
      smp_vld <= (gap_r == 0);
      gap_r   <= (gap_r == GAP - 1) ? 0 : gap_r + 1;
      if (gap_r == 0)
        idx_r <= idx_r + 1;
      for (int k = 0; k < NPH; k++) begin
        if (gap_r == 0) begin
          smp[k].v <= 24'(pos ? AMP_V : -AMP_V);
          smp[k].i <= 24'((pos ^ INV[k]) ? AMP_I : -AMP_I);
        end else begin
          smp[k] <= ~smp[k]; // Lines carry no valid data between strobes
        end
      end
    end
  end
endmodule

/* verif/testbench.sv */
// Bench for the metrology engine: frames, powers, totals and quadrants.
// Assumes the square-wave source model and a three-phase engine.
module testbench import emm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         AV  = 1000;         // Voltage amplitude
  localparam int         AI  = 2000;         // Current amplitude
  localparam longint     AB  = 64'(AV) * AI;
  localparam longint     N   = 7936;         // 62 periods of 128 samples
  localparam longint     X   = 200000;       // Reactive offset magnitude
  localparam longint     TOL = 20000;        // Slack from delay settling
  localparam longint     OP  = 10;           // Active offset
  localparam logic [2:0] INV = 3'b110;       // Phases with reversed current

  logic        clk;
  logic        rst_n;
  logic        smp_vld;
  emm_smp_t    smp [3];
  emm_cal_t    cal [3];
  logic        frame_done;
  emm_res_t    res [3];
  logic [31:0] freq_chz;
  logic [31:0] spc_q8;
  emm_nrg_t    nrg [4];
  emm_nrg_t    base [4];
  longint      oq [3];
  int          fail_count;
  int          checked;

  emm_src_model #(.NPH(3), .INV(INV)) i_src (
    .clk     (clk),
    .rst_n   (rst_n),
    .smp     (smp),
    .smp_vld (smp_vld)
  );

  emm_engine #(.NPH(3), .DEPTH(64)) i_dut (
    .clk        (clk),
    .rst_n      (rst_n),
    .smp_vld    (smp_vld),
    .smp        (smp),
    .cal        (cal),
    .frame_done (frame_done),
    .res        (res),
    .freq_chz   (freq_chz),
    .spc_q8     (spc_q8),
    .nrg        (nrg)
  );

  // Clock at 100 MHz
  initial clk = 1'b0;
  always #5 clk = ~clk;

  // Exact comparison
  task automatic check_val(input string what, input logic [63:0] got,
                           input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  // Comparison within a window
  task automatic check_near(input string what, input logic signed [63:0] got,
                            input longint exp, input longint tol);
    logic ok;
    ok = (got >= exp - tol) && (got <= exp + tol);
    checked++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("unexpected at %0t: %s got %0d near %0d", $time, what, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Bounded wait for the next frame result
  task automatic wait_frame();
    int n = 0;
    while (frame_done !== 1'b1 && n < 12000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 12000) begin
      fail_count++;
      $display("unexpected at %0t: no frame completion", $time);
    end
    @(posedge clk);
    #1;
  endtask

  // Outputs right after reset
  task automatic scen_reset_values();
    check_val("spc at reset", 64'(spc_q8), 64'h0000a000);
    check_val("freq at reset", 64'(freq_chz), 64'h0);
    for (int k = 0; k < 4; k++)
      check_val("totals at reset", {63'h0, |nrg[k]}, 64'h0);
  endtask

  // Reset in mid-frame clears the totals
  task automatic scen_mid_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    scen_reset_values();
  endtask

  // Levels, active power and import or export totals
  task automatic scen_frame_basic(input longint n);
    longint pe [4];
    longint ei;
    longint ee;
    wait_frame();
    for (int k = 0; k < 3; k++) begin
      pe[k] = (INV[k] ? -AB : AB) - OP;
      check_val("vrms", 64'(res[k].vrms), 64'(2 * AV - 5));
      check_val("irms", 64'(res[k].irms), 64'(AI));
      check_near("active power", res[k].p, pe[k], 0);
    end
    pe[3] = pe[0] + pe[1] + pe[2];
    for (int k = 0; k < 4; k++) begin
      ei = (pe[k] < 0) ? 0 : n * pe[k] * N;
      ee = (pe[k] < 0) ? -n * pe[k] * N : 0;
      check_val("import total", nrg[k].act_imp, 64'(ei));
      check_val("export total", nrg[k].act_exp, 64'(ee));
    end
  endtask

  // Frequency, reactive and apparent results, routing of totals
  task automatic check_quads();
    longint      pe [4];
    longint      qe [4];
    real         se [4];
    logic [63:0] d [6];
    real         pfe;
    int          qi;
    int          ai;
    check_val("samples per cycle", 64'(spc_q8), 64'h00008000);
    check_val("frequency", 64'(freq_chz), 64'd6250);
    for (int k = 0; k < 3; k++) begin
      pe[k] = (INV[k] ? -AB : AB) - OP;
      qe[k] = -oq[k];
      se[k] = $sqrt(real'(pe[k]) ** 2 + real'(qe[k]) ** 2);
      pfe = 16384.0 * ((pe[k] < 0) ? -pe[k] : pe[k]) / se[k];
      if (qe[k] >= 0)
        pfe = -pfe;
      check_near("reactive", res[k].q, qe[k], TOL);
      check_near("apparent", res[k].s, longint'(se[k]), TOL);
      check_near("power factor", res[k].pf, longint'(pfe), 64);
    end
    pe[3] = pe[0] + pe[1] + pe[2];
    qe[3] = qe[0] + qe[1] + qe[2];
    se[3] = se[0] + se[1] + se[2];
    for (int k = 0; k < 4; k++) begin
      d[0] = nrg[k].rq1 - base[k].rq1;
      d[1] = nrg[k].rq2 - base[k].rq2;
      d[2] = nrg[k].rq3 - base[k].rq3;
      d[3] = nrg[k].rq4 - base[k].rq4;
      d[4] = nrg[k].app_imp - base[k].app_imp;
      d[5] = nrg[k].app_exp - base[k].app_exp;
      qi = (qe[k] >= 0) ? ((pe[k] >= 0) ? 0 : 1) : ((pe[k] < 0) ? 2 : 3);
      ai = (pe[k] >= 0) ? 4 : 5;
      for (int j = 0; j < 6; j++) begin
        if (j == qi)
          check_near("quadrant", d[j], (qe[k] < 0 ? -qe[k] : qe[k]) * N,
                     3 * TOL * N);
        else if (j == ai)
          check_near("apparent total", d[j], longint'(se[k] * N),
                     3 * TOL * N);
        else
          check_val("unrouted total", d[j], 64'h0);
      end
    end
  endtask

  // Quadrants four, two, three per phase and three for the sum
  task automatic scen_quadrants();
    base = nrg;
    wait_frame();
    check_quads();
  endtask

  // Phase zero moves to quadrant one, the sum to quadrant two
  task automatic scen_quadrant_swap();
    @(posedge clk);
    cal[0].oq <= -32'(X);
    oq[0] = -X;
    base = nrg;
    wait_frame();
    check_quads();
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    fail_count = 0;
    checked = 0;
    oq = '{X, -X, X};
    for (int k = 0; k < 3; k++)
      cal[k] = '{32'h20000, 32'h10000, 32'h10000, 32'h10000,
                 32'd5, 32'd0, 32'(OP), 32'(oq[k])};
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    scen_reset_values();
    scen_frame_basic(1);
    scen_mid_reset();
    scen_frame_basic(1);
    scen_quadrants();
    scen_quadrant_swap();
    finish_test();
  end

  // Watchdog over the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    $display("unexpected at %0t: run did not complete", $time);
    finish_test();
  end
endmodule
